// *** hw/lsc_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lsc_defs.svh"

module lsc_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  output logic      [3:0]  second_slot_photodiode_select,
  output logic      [3:0]  first_slot_photodiode_select,
  output logic      [1:0]  second_slot_emitter_select,
  output logic      [1:0]  first_slot_emitter_select,
  output logic      [2:0]  second_slot_emitter_pulse_en,
  output logic      [2:0]  first_slot_emitter_pulse_en,
  output logic             second_slot_float_mode,
  output logic             second_slot_pulse_connect,
  output logic             first_slot_float_mode,
  output logic             first_slot_pulse_connect,
  output logic             driver_three_strength_scale,
  output logic             driver_three_low_power,
  output logic      [7:0]  driver_three_scale_pct,
  output logic      [2:0]  driver_three_edge_rate,
  output logic      [3:0]  driver_three_coarse_current,
  output logic      [15:0] driver_three_coarse_term,
  output logic             driver_one_strength_scale,
  output logic             driver_one_low_power,
  output logic      [7:0]  driver_one_scale_pct,
  output logic             slot_reserved_nonzero
);

  lsc_pkg::lsc_bank_state_type st_q;
  lsc_pkg::lsc_bank_state_type st_d;

  logic [15:0] slot_next;
  logic [15:0] three_next;
  logic [15:0] one_next;
  logic [15:0] coarse_ext;

  // ****************************************
  // Register write decode
  // ****************************************
  always_comb begin
    slot_next  = st_q.slot_sel;
    three_next = st_q.drv_three;
    one_next   = st_q.drv_one;
    if (reg_wr) begin
      case (reg_addr)
        `LSC_ADDR_SLOT_SEL: begin
          slot_next = reg_wdata;
        end
        `LSC_ADDR_DRV_THREE: begin
          three_next = reg_wdata;
        end
        `LSC_ADDR_DRV_ONE: begin
          one_next = reg_wdata;
        end
        default: begin
          slot_next = st_q.slot_sel;
        end
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    coarse_ext = {12'h000, three_next[`LSC_DRV_COARSE_HI:`LSC_DRV_COARSE_LO]};
    st_d       = st_q;

    st_d.slot_sel  = slot_next;
    st_d.drv_three = three_next;
    st_d.drv_one   = one_next;

    // Current terms in hundredths of a milliamp
    st_d.coarse_term = 16'(`LSC_COARSE_BASE_CENTI + `LSC_COARSE_STEP_CENTI * coarse_ext);

    if (three_next[`LSC_DRV_SCALE_BIT]) begin
      st_d.three_scale_pct = `LSC_SCALE_FULL_PCT;
      st_d.three_low_power = 1'b0;
    end else begin
      st_d.three_scale_pct = `LSC_SCALE_LOW_PCT;
      st_d.three_low_power = 1'b1;
    end

    if (one_next[`LSC_DRV_SCALE_BIT]) begin
      st_d.one_scale_pct = `LSC_SCALE_FULL_PCT;
      st_d.one_low_power = 1'b0;
    end else begin
      st_d.one_scale_pct = `LSC_SCALE_LOW_PCT;
      st_d.one_low_power = 1'b1;
    end

    // Software must keep these clear; shown for diagnosis
    st_d.reserved_nonzero = |slot_next[`LSC_SLOT_RSVD_HI:`LSC_SLOT_RSVD_LO];

    // Read port, one cycle latency
    st_d.rvalid = reg_rd;
    st_d.rdata  = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `LSC_ADDR_SLOT_SEL: begin
          st_d.rdata = st_q.slot_sel;
        end
        `LSC_ADDR_DRV_THREE: begin
          st_d.rdata = st_q.drv_three;
        end
        `LSC_ADDR_DRV_ONE: begin
          st_d.rdata = st_q.drv_one;
        end
        default: begin
          st_d.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q.slot_sel         <= `LSC_RST_SLOT_SEL;
      st_q.drv_three        <= `LSC_RST_DRV_THREE;
      st_q.drv_one          <= `LSC_RST_DRV_ONE;
      st_q.rdata            <= 16'h0000;
      st_q.rvalid           <= 1'b0;
      st_q.coarse_term      <= `LSC_COARSE_BASE_CENTI;
      st_q.three_scale_pct  <= `LSC_SCALE_FULL_PCT;
      st_q.one_scale_pct    <= `LSC_SCALE_FULL_PCT;
      st_q.three_low_power  <= 1'b0;
      st_q.one_low_power    <= 1'b0;
      st_q.reserved_nonzero <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Slot emitter decoders
  // ****************************************
  lsc_slot_decode u_second_slot (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .emitter_code     (slot_next[`LSC_SECOND_EMIT_HI:`LSC_SECOND_EMIT_LO]),
    .emitter_pulse_en (second_slot_emitter_pulse_en),
    .float_mode       (second_slot_float_mode),
    .pulse_connect    (second_slot_pulse_connect)
  );

  lsc_slot_decode u_first_slot (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .emitter_code     (slot_next[`LSC_FIRST_EMIT_HI:`LSC_FIRST_EMIT_LO]),
    .emitter_pulse_en (first_slot_emitter_pulse_en),
    .float_mode       (first_slot_float_mode),
    .pulse_connect    (first_slot_pulse_connect)
  );

  // ****************************************
  // Field outputs
  // ****************************************
  assign reg_rdata                     = st_q.rdata;
  assign reg_rvalid                    = st_q.rvalid;
  assign second_slot_photodiode_select = st_q.slot_sel[`LSC_SECOND_PD_HI:`LSC_SECOND_PD_LO];
  assign first_slot_photodiode_select  = st_q.slot_sel[`LSC_FIRST_PD_HI:`LSC_FIRST_PD_LO];
  assign second_slot_emitter_select    = st_q.slot_sel[`LSC_SECOND_EMIT_HI:`LSC_SECOND_EMIT_LO];
  assign first_slot_emitter_select     = st_q.slot_sel[`LSC_FIRST_EMIT_HI:`LSC_FIRST_EMIT_LO];
  assign driver_three_strength_scale   = st_q.drv_three[`LSC_DRV_SCALE_BIT];
  assign driver_three_low_power        = st_q.three_low_power;
  assign driver_three_scale_pct        = st_q.three_scale_pct;
  assign driver_three_edge_rate        = st_q.drv_three[`LSC_DRV_EDGE_HI:`LSC_DRV_EDGE_LO];
  assign driver_three_coarse_current   = st_q.drv_three[`LSC_DRV_COARSE_HI:`LSC_DRV_COARSE_LO];
  assign driver_three_coarse_term      = st_q.coarse_term;
  assign driver_one_strength_scale     = st_q.drv_one[`LSC_DRV_SCALE_BIT];
  assign driver_one_low_power          = st_q.one_low_power;
  assign driver_one_scale_pct          = st_q.one_scale_pct;
  assign slot_reserved_nonzero         = st_q.reserved_nonzero;

endmodule
`default_nettype wire

// *** hw/lsc_defs.svh ***
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LSC_ADDR_W             8
`define LSC_DATA_W             16
`define LSC_ADDR_SLOT_SEL      8'h14
`define LSC_ADDR_DRV_THREE     8'h22
`define LSC_ADDR_DRV_ONE       8'h23

// ****************************************
// Reset values
// ****************************************
`define LSC_RST_SLOT_SEL       16'h0541
`define LSC_RST_DRV_THREE      16'h3000
`define LSC_RST_DRV_ONE        16'h3000

// ****************************************
// Field positions
// ****************************************
`define LSC_SLOT_RSVD_HI       15
`define LSC_SLOT_RSVD_LO       12
`define LSC_SECOND_PD_HI       11
`define LSC_SECOND_PD_LO       8
`define LSC_FIRST_PD_HI        7
`define LSC_FIRST_PD_LO        4
`define LSC_SECOND_EMIT_HI     3
`define LSC_SECOND_EMIT_LO     2
`define LSC_FIRST_EMIT_HI      1
`define LSC_FIRST_EMIT_LO      0
`define LSC_DRV_SCALE_BIT      13
`define LSC_DRV_EDGE_HI        6
`define LSC_DRV_EDGE_LO        4
`define LSC_DRV_COARSE_HI      3
`define LSC_DRV_COARSE_LO      0

// ****************************************
// Emitter codes and current terms
// ****************************************
`define LSC_EMIT_NONE          2'h0
`define LSC_EMIT_ONE           2'h1
`define LSC_EMIT_TWO           2'h2
`define LSC_EMIT_THREE         2'h3
`define LSC_COARSE_BASE_CENTI  16'h1162
`define LSC_COARSE_STEP_CENTI  16'h06f4
`define LSC_SCALE_FULL_PCT     8'h64
`define LSC_SCALE_LOW_PCT      8'h0a

`endif

// *** hw/lsc_pkg.sv ***
package lsc_pkg;

  // ****************************************
  // Slot decoder state
  // ****************************************
  typedef struct packed {
    logic [2:0] emitter_pulse_en;
    logic       float_mode;
    logic       pulse_connect;
  } lsc_slot_state_type;

  // ****************************************
  // Register bank state
  // ****************************************
  typedef struct packed {
    logic [15:0] slot_sel;
    logic [15:0] drv_three;
    logic [15:0] drv_one;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] coarse_term;
    logic [7:0]  three_scale_pct;
    logic [7:0]  one_scale_pct;
    logic        three_low_power;
    logic        one_low_power;
    logic        reserved_nonzero;
  } lsc_bank_state_type;

endpackage

// *** hw/lsc_slot_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lsc_defs.svh"

module lsc_slot_decode (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [1:0] emitter_code,
  output logic      [2:0] emitter_pulse_en,
  output logic            float_mode,
  output logic            pulse_connect
);

  lsc_pkg::lsc_slot_state_type st_q;
  lsc_pkg::lsc_slot_state_type st_d;

  // ****************************************
  // Code to driver decode
  // ****************************************
  always_comb begin
    st_d = '0;
    case (emitter_code)
      `LSC_EMIT_ONE: begin
        st_d.emitter_pulse_en = 3'h1;
      end
      `LSC_EMIT_TWO: begin
        st_d.emitter_pulse_en = 3'h2;
      end
      `LSC_EMIT_THREE: begin
        st_d.emitter_pulse_en = 3'h4;
      end
      default: begin
        st_d.float_mode    = 1'b1;
        st_d.pulse_connect = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign emitter_pulse_en = st_q.emitter_pulse_en;
  assign float_mode       = st_q.float_mode;
  assign pulse_connect    = st_q.pulse_connect;

endmodule
`default_nettype wire

// *** test/lsc_regs_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module lsc_regs_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [3:0]  second_slot_photodiode_select,
  input wire logic [3:0]  first_slot_photodiode_select,
  input wire logic [1:0]  second_slot_emitter_select,
  input wire logic [1:0]  first_slot_emitter_select,
  input wire logic [2:0]  second_slot_emitter_pulse_en,
  input wire logic [2:0]  first_slot_emitter_pulse_en,
  input wire logic        second_slot_float_mode,
  input wire logic        second_slot_pulse_connect,
  input wire logic        first_slot_float_mode,
  input wire logic        first_slot_pulse_connect,
  input wire logic        driver_three_strength_scale,
  input wire logic        driver_three_low_power,
  input wire logic [7:0]  driver_three_scale_pct,
  input wire logic [2:0]  driver_three_edge_rate,
  input wire logic [3:0]  driver_three_coarse_current,
  input wire logic [15:0] driver_three_coarse_term,
  input wire logic        driver_one_strength_scale,
  input wire logic        driver_one_low_power,
  input wire logic [7:0]  driver_one_scale_pct,
  input wire logic        slot_reserved_nonzero
);
  // ****
  // Checks
  // ****
  logic [15:0] wd_q;
  always_ff @(posedge clk_sys) wd_q <= reg_wdata;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  unmapped_read_a: assert property (reg_rd && !(reg_addr inside {8'h14, 8'h22, 8'h23})
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  pd_write_a: assert property (reg_wr && reg_addr == 8'h14 |=>
    {second_slot_photodiode_select, first_slot_photodiode_select} == wd_q[11:4]) else $error("pd select wrong");
  emit_second_a: assert property ($past(rst_n) && second_slot_emitter_select != 2'h0 |->
    second_slot_emitter_pulse_en == 3'h1 << (second_slot_emitter_select - 2'h1)) else $error("second emitter");
  emit_first_a: assert property ($past(rst_n) && first_slot_emitter_select != 2'h0 |->
    first_slot_emitter_pulse_en == 3'h1 << (first_slot_emitter_select - 2'h1)) else $error("first emitter");
  idle_slot_a: assert property ($past(rst_n) |-> second_slot_pulse_connect == second_slot_float_mode &&
    second_slot_float_mode == (second_slot_emitter_select == 2'h0) &&
    first_slot_float_mode == (first_slot_emitter_select == 2'h0) &&
    first_slot_pulse_connect == first_slot_float_mode) else $error("float mode wrong");
  three_scale_a: assert property (driver_three_low_power != driver_three_strength_scale &&
    driver_three_scale_pct == (driver_three_strength_scale ? 8'h64 : 8'h0a)) else $error("three scale");
  one_scale_a: assert property (driver_one_low_power != driver_one_strength_scale &&
    driver_one_scale_pct == (driver_one_strength_scale ? 8'h64 : 8'h0a)) else $error("one scale");
  three_fields_a: assert property (reg_wr && reg_addr == 8'h22 |=>
    {driver_three_edge_rate, driver_three_coarse_current} == wd_q[6:0]) else $error("three fields");
  coarse_term_a: assert property (driver_three_coarse_term ==
    16'h1162 + 16'h06f4 * driver_three_coarse_current) else $error("coarse term");
  reserved_flag_a: assert property (reg_wr && reg_addr == 8'h14 |=>
    slot_reserved_nonzero == (wd_q[15:12] != 4'h0)) else $error("reserved flag wrong");
endmodule
bind lsc_regs lsc_regs_asserts u_chk (.*);
`default_nettype wire

// *** test/lsc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module lsc_host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = (a == 8'h14) ? {4'h0, d[11:0]} : d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr, reg_rd, reg_rvalid, s_fl, s_pc, f_fl, f_pc, t_str, t_lp, o_str, o_lp, v, r_nz;
  logic [1:0]  s_sel, f_sel;
  logic [2:0]  s_en, f_en, t_edge;
  logic [3:0]  s_pd, f_pd, t_crs;
  logic [7:0]  reg_addr, t_pct, o_pct;
  logic [15:0] reg_wdata, reg_rdata, t_term, rd, w;
  logic [31:0] seed = 32'h2136;
  logic [31:0] r;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #4 clk_sys = ~clk_sys;
  lsc_host_model host (.clk_sys, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  lsc_regs DUT (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .second_slot_photodiode_select(s_pd), .first_slot_photodiode_select(f_pd),
    .second_slot_emitter_select(s_sel), .first_slot_emitter_select(f_sel),
    .second_slot_emitter_pulse_en(s_en), .first_slot_emitter_pulse_en(f_en),
    .second_slot_float_mode(s_fl), .second_slot_pulse_connect(s_pc),
    .first_slot_float_mode(f_fl), .first_slot_pulse_connect(f_pc),
    .driver_three_strength_scale(t_str), .driver_three_low_power(t_lp), .driver_three_scale_pct(t_pct),
    .driver_three_edge_rate(t_edge), .driver_three_coarse_current(t_crs), .driver_three_coarse_term(t_term),
    .driver_one_strength_scale(o_str), .driver_one_low_power(o_lp), .driver_one_scale_pct(o_pct),
    .slot_reserved_nonzero(r_nz));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] en_of(input logic [1:0] c);
    return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
  endfunction
  task automatic chk_slot(input logic [15:0] x);
    `CHK("second pd", x[11:8], s_pd)
    `CHK("first pd", x[7:4], f_pd)
    `CHK("second en", en_of(x[3:2]), s_en)
    `CHK("first en", en_of(x[1:0]), f_en)
    `CHK("second idle", {2{x[3:2] == 2'h0}}, {s_fl, s_pc})
    `CHK("first idle", {2{x[1:0] == 2'h0}}, {f_fl, f_pc})
    `CHK("emit selects", x[3:0], {s_sel, f_sel})
    `CHK("reserved flag", |x[15:12], r_nz)
  endtask
  task automatic chk_drv(input logic [15:0] x);
    `CHK("three edge", x[6:4], t_edge)
    `CHK("three coarse", x[3:0], t_crs)
    `CHK("three term", 16'h1162 + 16'h06f4 * {12'h000, x[3:0]}, t_term)
    `CHK("three scale", {x[13], ~x[13], x[13] ? 8'h64 : 8'h0a}, {t_str, t_lp, t_pct})
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    host.read(a, rd, v);
    `CHK("read valid", 1'b1, v)
    `CHK("read data", e, rd)
  endtask
  task report_and_stop;
    $display("Mismatches %0d of %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop;
    end
  end
  // ****
  // Sequence
  // ****
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    chk_slot(16'h0541);
    chk_drv(16'h3000);
    `CHK("one scale", {1'b1, 1'b0, 8'h64}, {o_str, o_lp, o_pct})
    rd_chk(8'h14, 16'h0541);
    rd_chk(8'h22, 16'h3000);
    rd_chk(8'h23, 16'h3000);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      w = {4'h0, r[11:4], i[3:0]};
      host.write(8'h14, w);
      chk_slot(w);
      rd_chk(8'h14, w);
    end
    for (int i = 0; i < 16; i++) begin
      r = xs();
      w = {r[15:4], i[3:0]};
      host.write(8'h22, w);
      chk_drv(w);
      rd_chk(8'h22, w);
      host.write(8'h23, ~w);
      `CHK("one scale", {~w[13], w[13], ~w[13] ? 8'h64 : 8'h0a}, {o_str, o_lp, o_pct})
      rd_chk(8'h23, ~w);
    end
    host.write(8'h30, 16'hffff);
    rd_chk(8'h30, 16'h0000);
    rd_chk(8'h23, ~w);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b0;
    #1;
    chk_drv(16'h3000);
    `CHK("reset pd", 8'h54, {s_pd, f_pd})
    `CHK("reset sel", 4'h1, {s_sel, f_sel})
    `CHK("one scale", {1'b1, 1'b0, 8'h64}, {o_str, o_lp, o_pct})
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    chk_slot(16'h0541);
    rd_chk(8'h23, 16'h3000);
    report_and_stop;
  end
endmodule
`default_nettype wire
